// ### common/rotate_and_bank_select_unit_defines.vh
// Constants for the rotate and bank-select datapath slice.
// Included by the unit and its rotator; holds definitions only.
`ifndef ROTATE_AND_BANK_SELECT_UNIT_DEFINES_VH
`define ROTATE_AND_BANK_SELECT_UNIT_DEFINES_VH

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define OPC_ROTATE_LEFT      8'h90
`define OPC_ROTATE_LEFT_C    8'h10
`define OPC_ROTATE_RIGHT     8'hE0
`define OPC_ROTATE_RIGHT_C   8'hC0
`define OPC_IND_BIT          0
`define OPC_SELECT_BANK_ZERO 8'h4F

// ----------------------------------------------------------------
// Rotate operation codes
// ----------------------------------------------------------------
`define ROT_LEFT             2'h0
`define ROT_LEFT_C           2'h1
`define ROT_RIGHT            2'h2
`define ROT_RIGHT_C          2'h3

// ----------------------------------------------------------------
// Flag register bit positions
// ----------------------------------------------------------------
`define FLAG_C               7
`define FLAG_Z               6
`define FLAG_S               5
`define FLAG_V               4
`define FLAG_D               3
`define FLAG_H               2
`define FLAG_BANK            0
`define FLAGS_RESET          8'h00

// ----------------------------------------------------------------
// Timing and sizes
// ----------------------------------------------------------------
`define INSTR_CYCLES         3'h4
`define REG_ADDR_W           8
`define MSB                  7
`define LSB                  0

// ----------------------------------------------------------------
// APB map (byte addresses)
// ----------------------------------------------------------------
`define APB_AW               12
`define OFS_CTRL             12'h000
`define OFS_STATUS           12'h004
`define OFS_FLAGS            12'h008
`define OFS_REGS             12'h400
`define CTRL_EN              0
`define STAT_BUSY            0
`define STAT_BADOP           1
`define CTRL_RESET           1'h1

`endif

// ### rtl/rotator.v
// Single-bit byte rotator with its flag results.
// Purely combinational; the caller registers everything.
`timescale 1ns/1ps
`include "rotate_and_bank_select_unit_defines.vh"

module rotator (
	input  wire [1:0] op,
	input  wire [7:0] operand,
	input  wire       carry_in,
	output reg  [7:0] result,
	output reg        carry_out,
	output wire       zero,
	output wire       sign,
	output wire       overflow
);

	always @* begin
		case (op)
			`ROT_LEFT: begin
				result    = {operand[6:0], operand[`MSB]};
				carry_out = operand[`MSB];
			end
			`ROT_LEFT_C: begin
				result    = {operand[6:0], carry_in};
				carry_out = operand[`MSB];
			end
			`ROT_RIGHT: begin
				result    = {operand[`LSB], operand[7:1]};
				carry_out = operand[`LSB];
			end
			default: begin
				result    = {carry_in, operand[7:1]};
				carry_out = operand[`LSB];
			end
		endcase
	end

	assign zero     = (result == 8'h00);
	assign sign     = result[`MSB];
	assign overflow = result[`MSB] ^ operand[`MSB];

endmodule

// ### rtl/rotate_and_bank_select_unit.v
// Rotate and bank-select execution slice with its own register file.
// Assumes a decoder that offers one instruction at a time on the
// ins_* port and an APB master for software access.
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "rotate_and_bank_select_unit_defines.vh"

module rotate_and_bank_select_unit #(
	parameter NUM_REGS = 256
) (
	input  wire                clk,
	input  wire                sys_rst,
	input  wire                ins_valid,
	input  wire [7:0]          ins_opcode,
	input  wire [7:0]          ins_operand,
	output reg                 ins_ready_r,
	output reg                 ins_done_r,
	output reg  [7:0]          flags_r,
	input  wire                psel,
	input  wire                penable,
	input  wire                pwrite,
	input  wire [`APB_AW-1:0]  paddr,
	input  wire [31:0]         pwdata,
	output reg  [31:0]         prdata,
	output reg                 pready,
	output reg                 pslverr
);

	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	localparam [1:0] ST_IDLE = 2'b00;
	localparam [1:0] ST_PTR  = 2'b01;
	localparam [1:0] ST_EXEC = 2'b10;
	localparam [1:0] ST_HOLD = 2'b11;

	// Bit positions in the register-select vector of csr_decode.
	localparam       SEL_CTRL   = 0;
	localparam       SEL_STATUS = 1;
	localparam       SEL_FLAGS  = 2;
	localparam       SEL_WINDOW = 3;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	// Returns {known, bank_zero, indirect, rot_op[1:0]}.
	function [4:0] decode_op;
		input [7:0] opc;
		reg   [7:0] base;
		begin
			base      = {opc[7:1], 1'b0};
			decode_op = 5'h00;
			if (opc == `OPC_SELECT_BANK_ZERO) begin
				decode_op = 5'h18;
			end else if (base == `OPC_ROTATE_LEFT) begin
				decode_op = {3'b100, `ROT_LEFT};
			end else if (base == `OPC_ROTATE_LEFT_C) begin
				decode_op = {3'b100, `ROT_LEFT_C};
			end else if (base == `OPC_ROTATE_RIGHT) begin
				decode_op = {3'b100, `ROT_RIGHT};
			end else if (base == `OPC_ROTATE_RIGHT_C) begin
				decode_op = {3'b100, `ROT_RIGHT_C};
			end
			decode_op[2] = decode_op[4] & ~decode_op[3] & opc[`OPC_IND_BIT];
		end
	endfunction

	// Returns the register index selected by an APB address, or flags
	// an address outside the register window.
	function [`REG_ADDR_W:0] reg_index;
		input [`APB_AW-1:0] addr;
		reg   [`APB_AW-1:0] rel;
		begin
			rel       = addr - `OFS_REGS;
			reg_index = {1'b1, rel[`REG_ADDR_W+1:2]};
			if (addr < `OFS_REGS || rel[1:0] != 2'b00 ||
			    rel[`APB_AW-1:2] >= NUM_REGS) begin
				reg_index = {1'b0, rel[`REG_ADDR_W+1:2]};
			end
		end
	endfunction

	// Returns a one-hot select for an APB address; all zero marks an
	// unmapped address, which the read side answers with an error.
	function [3:0] csr_decode;
		input [`APB_AW-1:0] addr;
		input               in_window;
		begin
			csr_decode = 4'h0;
			if (addr == `OFS_CTRL) begin
				csr_decode[SEL_CTRL] = 1'b1;
			end else if (addr == `OFS_STATUS) begin
				csr_decode[SEL_STATUS] = 1'b1;
			end else if (addr == `OFS_FLAGS) begin
				csr_decode[SEL_FLAGS] = 1'b1;
			end else if (in_window) begin
				csr_decode[SEL_WINDOW] = 1'b1;
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// Storage and state
	// ----------------------------------------------------------------
	reg  [7:0]             regs [0:NUM_REGS-1];
	reg  [1:0]             state_r;
	reg  [1:0]             state_nxt;
	reg  [2:0]             cyc_r;
	reg  [4:0]             dec_r;
	reg  [7:0]             operand_r;
	reg  [`REG_ADDR_W-1:0] addr_r;
	reg                    en_r;
	reg                    badop_r;
	reg  [31:0]            rdata_nxt;
	reg                    rerr_nxt;
	reg  [7:0]             flags_nxt;

	wire                   accept;
	wire                   apb_go;
	wire                   apb_wr;
	wire [4:0]             dec_in;
	wire [`REG_ADDR_W:0]   ridx;
	wire [7:0]             rot_res;
	wire                   rot_c;
	wire                   rot_z;
	wire                   rot_s;
	wire                   rot_v;
	wire [3:0]             csr_sel;
	wire                   wr_ctrl;
	wire                   wr_status;
	wire                   wr_flags;
	wire                   wr_reg;
	wire                   exec_rot;
	wire                   exec_bank;

	assign dec_in = decode_op(ins_opcode);
	assign accept = ins_valid & ins_ready_r;
	assign ridx   = reg_index(paddr);
	// APB is served only while the sequencer is idle.
	assign apb_go = psel & penable & ~pready & (state_r == ST_IDLE) & ~accept;
	assign apb_wr = psel & penable & pready & pwrite & ~pslverr;

	// ----------------------------------------------------------------
	// Write and execute strobes
	// ----------------------------------------------------------------
	assign csr_sel   = csr_decode(paddr, ridx[`REG_ADDR_W]);
	assign wr_ctrl   = apb_wr & csr_sel[SEL_CTRL];
	assign wr_status = apb_wr & csr_sel[SEL_STATUS];
	assign wr_flags  = apb_wr & csr_sel[SEL_FLAGS];
	assign wr_reg    = apb_wr & csr_sel[SEL_WINDOW];
	// Rotates and bank-zero commit on the edge that ends the execute cycle.
	assign exec_rot  = (state_r == ST_EXEC) & dec_r[4] & ~dec_r[3];
	assign exec_bank = (state_r == ST_EXEC) & dec_r[4] & dec_r[3];

	// ----------------------------------------------------------------
	// Rotator
	// ----------------------------------------------------------------
	rotator u_rotator (
		.op        (dec_r[1:0]),
		.operand   (regs[addr_r]),
		.carry_in  (flags_r[`FLAG_C]),
		.result    (rot_res),
		.carry_out (rot_c),
		.zero      (rot_z),
		.sign      (rot_s),
		.overflow  (rot_v)
	);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (accept) begin
					state_nxt = ST_PTR;
				end
			end
			ST_PTR: begin
				state_nxt = ST_EXEC;
			end
			ST_EXEC: begin
				state_nxt = ST_HOLD;
			end
			default: begin
				if (cyc_r == `INSTR_CYCLES - 3'h1) begin
					state_nxt = ST_IDLE;
				end
			end
		endcase
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			state_r     <= ST_IDLE;
			cyc_r       <= 3'h0;
			dec_r       <= 5'h00;
			operand_r   <= 8'h00;
			addr_r      <= {`REG_ADDR_W{1'b0}};
			ins_ready_r <= 1'b0;
			ins_done_r  <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			ins_ready_r <= (state_nxt == ST_IDLE) & en_r & ~psel;
			ins_done_r  <= (state_r == ST_HOLD) & (state_nxt == ST_IDLE);
			if (accept) begin
				dec_r     <= dec_in;
				operand_r <= ins_operand;
				cyc_r     <= 3'h1;
			end else if (state_r != ST_IDLE) begin
				cyc_r     <= cyc_r + 3'h1;
			end
			if (state_r == ST_PTR) begin
				if (dec_r[2]) begin
					addr_r <= regs[operand_r[`REG_ADDR_W-1:0]];
				end else begin
					addr_r <= operand_r[`REG_ADDR_W-1:0];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Register file write port
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (exec_rot) begin
			regs[addr_r] <= rot_res;
		end else if (wr_reg) begin
			regs[ridx[`REG_ADDR_W-1:0]] <= pwdata[7:0];
		end
	end

	// ----------------------------------------------------------------
	// Flag register
	// ----------------------------------------------------------------
	// APB is served only while the sequencer is idle, so a software write
	// and an instruction never update the flags on the same edge.
	always @* begin
		flags_nxt = flags_r;
		if (exec_bank) begin
			flags_nxt[`FLAG_BANK] = 1'b0;
		end else if (exec_rot) begin
			flags_nxt[`FLAG_C] = rot_c;
			flags_nxt[`FLAG_Z] = rot_z;
			flags_nxt[`FLAG_S] = rot_s;
			flags_nxt[`FLAG_V] = rot_v;
			flags_nxt[`FLAG_D] = flags_r[`FLAG_D];
			flags_nxt[`FLAG_H] = flags_r[`FLAG_H];
		end else if (wr_flags) begin
			flags_nxt = pwdata[7:0];
		end
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			flags_r <= `FLAGS_RESET;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Control and status
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (sys_rst) begin
			en_r    <= `CTRL_RESET;
			badop_r <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				en_r <= pwdata[`CTRL_EN];
			end
			// A new bad opcode wins over a software clear.
			if (state_r == ST_EXEC && !dec_r[4]) begin
				badop_r <= 1'b1;
			end else if (wr_status && pwdata[`STAT_BADOP]) begin
				badop_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// APB read mux
	// ----------------------------------------------------------------
	always @* begin
		rdata_nxt = 32'h0000_0000;
		rerr_nxt  = 1'b0;
		if (csr_sel[SEL_CTRL]) begin
			rdata_nxt[`CTRL_EN] = en_r;
		end else if (csr_sel[SEL_STATUS]) begin
			rdata_nxt[`STAT_BUSY]  = (state_r != ST_IDLE);
			rdata_nxt[`STAT_BADOP] = badop_r;
		end else if (csr_sel[SEL_FLAGS]) begin
			rdata_nxt[7:0] = flags_r;
		end else if (csr_sel[SEL_WINDOW]) begin
			rdata_nxt[7:0] = regs[ridx[`REG_ADDR_W-1:0]];
		end else begin
			rerr_nxt = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// APB handshake
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (apb_go) begin
			pready  <= 1'b1;
			pslverr <= rerr_nxt;
			prdata  <= pwrite ? 32'h0000_0000 : rdata_nxt;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
	end

endmodule

// ### tb/rotate_and_bank_select_unit_assertions.sv
// Checker for the rotate and bank-select slice.
// Assumes it is bound to the unit and sees its ports only.
`timescale 1ns/1ps
`include "rotate_and_bank_select_unit_defines.vh"

module rotate_and_bank_select_unit_assertions #(
	parameter NUM_REGS = 256
) (
	input wire       clk,
	input wire       sys_rst,
	input wire       ins_valid,
	input wire [7:0] ins_opcode,
	input wire       ins_ready_r,
	input wire       ins_done_r,
	input wire [7:0] flags_r
);
	wire       take = ins_valid && ins_ready_r;
	wire [7:0] opc  = {ins_opcode[7:1], 1'h0};
	wire       rot  = opc == `OPC_ROTATE_LEFT || opc == `OPC_ROTATE_LEFT_C
		|| opc == `OPC_ROTATE_RIGHT || opc == `OPC_ROTATE_RIGHT_C;

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	// The unit stays busy three cycles, then finishes once.
	sequence busy_run;
		(!ins_ready_r && !ins_done_r) [*3] ##1 ins_done_r;
	endsequence

	take_to_done_a: assert property (take |=> busy_run)
		else $error("done not four cycles after take");
	bank_zero_a: assert property (take && ins_opcode == `OPC_SELECT_BANK_ZERO
		|-> ##4 flags_r == {$past(flags_r[7:1], 4), 1'h0}) else $error("bank clear wrong");
	keep_dh_a: assert property (take && rot
		|-> ##4 flags_r[3:2] == $past(flags_r[3:2], 4)) else $error("D or H changed");
	right_sign_a: assert property (take && opc == `OPC_ROTATE_RIGHT
		|-> ##4 flags_r[5] == flags_r[7]) else $error("right sign differs from carry");
	rrc_sign_a: assert property (take && opc == `OPC_ROTATE_RIGHT_C
		|-> ##4 flags_r[5] == $past(flags_r[7], 4)) else $error("sign not old carry");
	left_zero_a: assert property (take && opc == `OPC_ROTATE_LEFT
		|-> ##4 !(flags_r[6] && flags_r[7])) else $error("zero with carry set");
	rlc_zero_a: assert property (take && opc == `OPC_ROTATE_LEFT_C
		|-> ##4 !(flags_r[6] && $past(flags_r[7], 4))) else $error("zero with old carry");
	zero_sign_a: assert property (take && rot
		|-> ##4 !(flags_r[6] && flags_r[5])) else $error("zero and sign both set");
endmodule

bind rotate_and_bank_select_unit rotate_and_bank_select_unit_assertions #(
	.NUM_REGS(NUM_REGS)
) chk_u (
	.clk(clk), .sys_rst(sys_rst), .ins_valid(ins_valid), .ins_opcode(ins_opcode),
	.ins_ready_r(ins_ready_r), .ins_done_r(ins_done_r), .flags_r(flags_r)
);

// ### tb/instr_source.sv
// Decoder model that offers one instruction at a time.
// Assumes its task is called just after a rising clock edge.
`timescale 1ns/1ps

module instr_source (
	input  wire       clk,
	input  wire       ins_ready_r,
	output reg        ins_valid,
	output reg  [7:0] ins_opcode,
	output reg  [7:0] ins_operand
);
	initial begin
		ins_valid = 1'h0;
		ins_opcode = 8'h00;
		ins_operand = 8'h00;
	end

	// Lines show inverted values once released so stale data never matches.
	task issue(input [7:0] opc, input [7:0] opr, input integer gap);
		repeat (gap) @(posedge clk);
		ins_valid <= 1'h1;
		ins_opcode <= opc;
		ins_operand <= opr;
		do @(posedge clk); while (ins_ready_r !== 1'h1);
		ins_valid <= 1'h0;
		ins_opcode <= ~opc;
		ins_operand <= ~opr;
		@(posedge clk);
	endtask
endmodule

// ### tb/tb_rotate_and_bank_select_unit.sv
// Self-checking bench for the rotate and bank-select slice.
// Assumes the decoder model and the bound checker are compiled with it.
`timescale 1ns/1ps
`include "rotate_and_bank_select_unit_defines.vh"

module tb_rotate_and_bank_select_unit;
	reg                clk;
	reg                sys_rst;
	reg                psel;
	reg                penable;
	reg                pwrite;
	reg  [`APB_AW-1:0] paddr;
	reg  [31:0]        pwdata;
	wire [31:0]        prdata;
	wire               pready;
	wire               pslverr;
	wire               ins_valid;
	wire [7:0]         ins_opcode;
	wire [7:0]         ins_operand;
	wire               ins_ready_r;
	wire               ins_done_r;
	wire [7:0]         flags_r;
	integer            err_count = 0;
	integer            check_count = 0;
	integer            cycles = 0;

	rotate_and_bank_select_unit #(.NUM_REGS(256)) dut_u (
		.clk(clk), .sys_rst(sys_rst), .ins_valid(ins_valid), .ins_opcode(ins_opcode),
		.ins_operand(ins_operand), .ins_ready_r(ins_ready_r), .ins_done_r(ins_done_r),
		.flags_r(flags_r), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	instr_source src_u (.clk(clk), .ins_ready_r(ins_ready_r), .ins_valid(ins_valid),
		.ins_opcode(ins_opcode), .ins_operand(ins_operand));

	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			err_count = err_count + 1;
			summarize;
		end
	end

	task summarize;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task chk(input string name, input [31:0] exp, input [31:0] got);
		check_count = check_count + 1;
		if (got !== exp) begin
			err_count = err_count + 1;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	// ----------------------------------------------------------------
	// APB and instruction helpers
	// ----------------------------------------------------------------
	task apb(input is_wr, input [11:0] a, input [31:0] d, output [31:0] q, output e);
		psel <= 1'h1;
		pwrite <= is_wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		paddr <= ~a;
		pwdata <= ~d;
		@(posedge clk);
	endtask

	task wr(input [11:0] a, input [31:0] d);
		reg [31:0] q;
		reg        e;
		apb(1'h1, a, d, q, e);
	endtask

	task rd_chk(input string name, input [11:0] a, input [31:0] exp);
		reg [31:0] q;
		reg        e;
		apb(1'h0, a, 32'h0, q, e);
		chk(name, exp, q);
	endtask

	function [11:0] ra(input [7:0] n);
		ra = `OFS_REGS + {2'h0, n, 2'h0};
	endfunction

	task run(input [7:0] opc, input [7:0] opr, input integer gap);
		integer n;
		src_u.issue(opc, opr, gap);
		n = 0;
		while (ins_done_r !== 1'h1 && n < 8) begin
			@(posedge clk);
			n = n + 1;
		end
		chk("done", 32'h1, {31'h0, ins_done_r});
		chk("done cycles", 32'h3, n);
	endtask

	function [15:0] rot_exp(input [1:0] op, input [7:0] v, input [7:0] f);
		reg [7:0] r;
		begin
			case (op)
			2'h0: r = {v[6:0], v[7]};
			2'h1: r = {v[6:0], f[7]};
			2'h2: r = {v[0], v[7:1]};
			default: r = {f[7], v[7:1]};
			endcase
			rot_exp = {r, op[1] ? v[0] : v[7], r == 8'h00, r[7], r[7] ^ v[7], f[3:0]};
		end
	endfunction

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_regs;
		reg [31:0] q;
		reg        e;
		rd_chk("ctrl", `OFS_CTRL, 32'h1);
		rd_chk("flags", `OFS_FLAGS, 32'h0);
		apb(1'h0, 12'h00C, 32'h0, q, e);
		chk("unmapped err", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, q);
		wr(`OFS_CTRL, 32'h0);
		repeat (3) @(posedge clk);
		chk("ready off", 32'h0, {31'h0, ins_ready_r});
		wr(`OFS_CTRL, 32'h1);
		run(8'h00, 8'h11, 0);
		rd_chk("badop", `OFS_STATUS, 32'h2);
		wr(`OFS_STATUS, 32'h2);
		rd_chk("badop clr", `OFS_STATUS, 32'h0);
	endtask

	task t_rotates;
		integer    op, m, k, c;
		reg [7:0]  v, f, o, t;
		reg [15:0] e;
		for (op = 0; op < 4; op = op + 1) for (m = 0; m < 2; m = m + 1)
		for (k = 0; k < 4; k = k + 1) for (c = 0; c < 2; c = c + 1) begin
			v = (k == 0) ? 8'hAA : (k == 1) ? 8'h55 : (k == 2) ? 8'h80 : 8'h01;
			f = {c[0], 3'h6, k[0], ~k[0], k[1], 1'h1};
			o = (op == 0) ? `OPC_ROTATE_LEFT : (op == 1) ? `OPC_ROTATE_LEFT_C
				: (op == 2) ? `OPC_ROTATE_RIGHT : `OPC_ROTATE_RIGHT_C;
			t = m ? 8'h22 : 8'h11;
			wr(ra(t), {24'h0, v});
			wr(ra(8'h05), 32'h22);
			wr(`OFS_FLAGS, {24'h0, f});
			run(o | {7'h0, m[0]}, m ? 8'h05 : 8'h11, c);
			e = rot_exp(op[1:0], v, f);
			rd_chk("result", ra(t), {24'h0, e[15:8]});
			rd_chk("flags", `OFS_FLAGS, {24'h0, e[7:0]});
			rd_chk("pointer", ra(8'h05), 32'h22);
		end
	endtask

	task t_bank;
		wr(`OFS_FLAGS, 32'hFF);
		run(`OPC_SELECT_BANK_ZERO, 8'h00, 0);
		chk("flags port", 32'hFE, {24'h0, flags_r});
		rd_chk("bank ff", `OFS_FLAGS, 32'hFE);
		wr(`OFS_FLAGS, 32'h55);
		run(`OPC_SELECT_BANK_ZERO, 8'hAA, 2);
		rd_chk("bank 55", `OFS_FLAGS, 32'h54);
	endtask

	task t_b2b;
		wr(ra(8'h03), 32'h81);
		wr(`OFS_FLAGS, 32'h0);
		src_u.issue(`OPC_ROTATE_LEFT, 8'h03, 0);
		run(`OPC_ROTATE_LEFT, 8'h03, 0);
		rd_chk("b2b result", ra(8'h03), 32'h06);
		rd_chk("b2b flags", `OFS_FLAGS, 32'h00);
	endtask

	initial begin
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		sys_rst = 1'h1;
		repeat (5) @(posedge clk);
		sys_rst <= 1'h0;
		@(posedge clk);
		t_regs;
		t_rotates;
		t_bank;
		t_b2b;
		summarize;
	end
endmodule
